// ==== common/adc_pkg.sv ====
// Purpose: Shared constants and types for the asynchronous DRAM cycle controller.
// Assumes: 100 MHz clock; the fastest speed grade figures of the memory.
// Notes: Times are kept in ns, the power-up pause in us, and turned into whole cycles here.
package adc_pkg;

  localparam int CLK_NS = 10;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 10;
  localparam int DQ_W = 4;

  // Request kinds accepted on the user port.
  typedef enum logic [2:0]
  {
    K_READ = 3'h0,
    K_EARLY_WRITE = 3'h1,
    K_DELAYED_WRITE = 3'h2,
    K_RMW = 3'h3,
    K_RAS_REFRESH = 3'h4,
    K_CBR_REFRESH = 3'h5,
    K_TEST_ENTER = 3'h6,
    K_TEST_EXIT = 3'h7
  } adc_kind_t;

  typedef enum logic [3:0]
  {
    ST_PAUSE = 4'h0,
    ST_IDLE = 4'h1,
    ST_ROW_SET = 4'h2,
    ST_ROW = 4'h3,
    ST_COL_SET = 4'h4,
    ST_COL = 4'h5,
    ST_OE_OFF = 4'h6,
    ST_WE_LOW = 4'h7,
    ST_PAGE_GAP = 4'h8,
    ST_CBR_CAS = 4'h9,
    ST_CBR_RAS = 4'hA,
    ST_END = 4'hB,
    ST_PRECHARGE = 4'hC
  } adc_state_t;

  // Least times round up to whole cycles.
  function automatic int cyc_up(input int ns);
    cyc_up = (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  function automatic int max3(input int a, input int b, input int c);
    max3 = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
  endfunction

  localparam int T_RAS_NS = 60;
  localparam int T_RP_NS = 40;
  localparam int T_RCD_NS = 20;
  localparam int T_CAS_NS = 15;
  localparam int T_ROW_ACCESS_NS = 60;
  localparam int T_CAC_NS = 15;
  localparam int T_AA_NS = 30;
  localparam int T_TEST_EXTRA_NS = 5;
  localparam int T_COL_FIRST_SETUP_NS = 10;
  localparam int T_PAGE_CYCLE_NS = 40;
  localparam int T_PAGE_ROW_WIDTH_NS = 100000;
  localparam int T_RWD_NS = 80;
  localparam int T_CWD_NS = 35;
  localparam int T_AWD_NS = 50;
  localparam int T_ODD_NS = 15;
  localparam int T_WP_NS = 10;
  localparam int T_WCH_NS = 15;
  localparam int T_DH_NS = 15;
  localparam int T_CWL_NS = 15;
  localparam int T_RWC_NS = 150;
  localparam int T_INIT_US = 100;
  localparam int INIT_REFRESHES_N = 8;

  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_SAT = 16'hFFFF;
  localparam logic [CNT_W-1:0] RAS_CYC = CNT_W'(cyc_up(T_RAS_NS));
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(cyc_up(T_RP_NS));
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(cyc_up(T_RCD_NS));
  localparam logic [CNT_W-1:0] ROW_ACCESS_CYC = CNT_W'(cyc_up(T_ROW_ACCESS_NS));
  localparam logic [CNT_W-1:0] COL_FIRST_SETUP_CYC = CNT_W'(cyc_up(T_COL_FIRST_SETUP_NS));
  localparam logic [CNT_W-1:0] PAGE_CYCLE_CYC = CNT_W'(cyc_up(T_PAGE_CYCLE_NS));
  localparam logic [CNT_W-1:0] OE_OFF_CYC = CNT_W'(cyc_up(T_ODD_NS));
  localparam logic [CNT_W-1:0] ACC_NORM_CYC = CNT_W'(max3(
    cyc_up(T_ROW_ACCESS_NS) - cyc_up(T_RCD_NS),
    cyc_up(T_CAC_NS), cyc_up(T_AA_NS)));
  localparam logic [CNT_W-1:0] ACC_TEST_CYC = CNT_W'(max3(
    cyc_up(T_ROW_ACCESS_NS + T_TEST_EXTRA_NS) - cyc_up(T_RCD_NS),
    cyc_up(T_CAC_NS + T_TEST_EXTRA_NS), cyc_up(T_AA_NS + T_TEST_EXTRA_NS)));
  localparam logic [CNT_W-1:0] WE_DLY_CYC = CNT_W'(max3(cyc_up(T_RWD_NS) - cyc_up(T_RCD_NS),
    cyc_up(T_CWD_NS), cyc_up(T_AWD_NS)));
  localparam logic [CNT_W-1:0] WE_LOW_CYC = CNT_W'(max3(cyc_up(T_WP_NS), cyc_up(T_DH_NS),
    cyc_up(T_CWL_NS)));
  localparam logic [CNT_W-1:0] EW_CAS_CYC = CNT_W'(max3(cyc_up(T_CAS_NS), cyc_up(T_DH_NS),
    cyc_up(T_WCH_NS)));
  localparam logic [CNT_W-1:0] PAGE_SLACK_CYC = CNT_W'(cyc_up(T_RWC_NS));
  localparam logic [CNT_W-1:0] INIT_REFRESHES = CNT_W'(INIT_REFRESHES_N);
  // Longest time rounds down.
  localparam int PAGE_MAX_DEF = T_PAGE_ROW_WIDTH_NS / CLK_NS;
  localparam int INIT_PAUSE_DEF = T_INIT_US * 1000 / CLK_NS;

endpackage

// ==== logic/adc_ctrl.sv ====
// Purpose: Controller that runs read, write, refresh and test cycles on an async DRAM.
// Assumes: Memory pins sampled and driven on clk; one request at a time.
// Notes: Refresh scheduling is left to the user; there is no refresh timer.
// Notes on behaviour
// - Never sample data when WE timing is neither early nor late enough.
// - Write data set at CAS fall in early write, at WE fall otherwise.
// - After power-up wait the pause, then at least eight refresh cycles.
// - Those eight refreshes are CAS-before-RAS so the internal counter works.
// - Test mode entered by a refresh with WE and CAS low before RAS.
// - In test mode refresh only by reads or WE-and-CAS-first refresh.
// - Test mode left by a RAS-only or CAS-before-RAS refresh.
// - In late writes take OE high before driving data.
// - Page mode holds RAS low no longer than the page maximum.
// - Page column cycles spaced no closer than the page cycle time.
// - CAS-first refresh: CAS low a setup before RAS falls and held after.
`timescale 1ns/1ps
module adc_ctrl
#(
  parameter int INIT_PAUSE_CYC = adc_pkg::INIT_PAUSE_DEF,
  parameter int PAGE_MAX_CYC = adc_pkg::PAGE_MAX_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request port
  input wire logic reqValid,
  input wire adc_pkg::adc_kind_t reqKind,
  input wire logic [adc_pkg::ADDR_W-1:0] reqRow,
  input wire logic [adc_pkg::ADDR_W-1:0] reqCol,
  input wire logic [adc_pkg::DQ_W-1:0] reqData,
  output logic reqReady,
  // Answer port
  output logic rspValid,
  output logic [adc_pkg::DQ_W-1:0] rspData,
  output logic testPass,
  // Status
  output logic initDone,
  output logic testActive,
  // Memory pins
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic oeN,
  output logic [adc_pkg::ADDR_W-1:0] addr,
  input wire logic [adc_pkg::DQ_W-1:0] dqIn,
  output logic [adc_pkg::DQ_W-1:0] dqOut,
  output logic dqOeN
);
  import adc_pkg::*;

  localparam logic [CNT_W-1:0] PAUSE_LOAD = CNT_W'(INIT_PAUSE_CYC - 1);
  localparam logic [CNT_W-1:0] PAGE_LIMIT = CNT_W'(PAGE_MAX_CYC);

  adc_state_t state;
  adc_kind_t kind;
  logic [CNT_W-1:0] tmr;
  logic [CNT_W-1:0] initCnt;
  logic [ADDR_W-1:0] row;
  logic [ADDR_W-1:0] col;
  logic [DQ_W-1:0] wdata;
  logic casFallP;
  logic [CNT_W-1:0] rasLow;
  logic [CNT_W-1:0] casLow;
  logic [CNT_W-1:0] casGap;
  logic [CNT_W-1:0] accNeed;
  logic take;
  logic pageMatch;
  logic pageRoom;
  logic spacingOk;
  logic sampleNow;
  logic driveWant;
  logic isEarly;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counters for strobe timing.

  adc_delay_count u_ras_low
  (
    .clk(clk),
    .rst(rst),
    .clr(rasN),
    .count(rasLow)
  );

  adc_delay_count u_cas_low
  (
    .clk(clk),
    .rst(rst),
    .clr(casN),
    .count(casLow)
  );

  adc_delay_count u_cas_gap
  (
    .clk(clk),
    .rst(rst),
    .clr(casFallP),
    .count(casGap)
  );

  adc_data_pins u_data
  (
    .clk(clk),
    .rst(rst),
    .driveWant(driveWant),
    .wrData(wdata),
    .sampleNow(sampleNow),
    .dqIn(dqIn),
    .dqOut(dqOut),
    .dqOeN(dqOeN),
    .rdData(rspData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decisions taken from the current state.

  assign isEarly = (kind == K_EARLY_WRITE);
  // The slower test-mode figure is used whenever test mode is on.
  assign accNeed = testActive ? ACC_TEST_CYC : ACC_NORM_CYC;
  assign pageMatch = (reqRow == row) && (reqKind == kind);
  // Leave room for one more column cycle and the closing of the row.
  assign pageRoom = (rasLow + PAGE_SLACK_CYC) < PAGE_LIMIT;
  // One set-up cycle follows the take, so the spacing check is two short.
  // Comparing the counter itself avoids a wrap once it has saturated.
  assign spacingOk = casGap >= (PAGE_CYCLE_CYC - CNT_ONE - CNT_ONE);
  assign take = reqValid && reqReady && ((state == ST_IDLE) ||
    (state == ST_PAGE_GAP && pageMatch && spacingOk && pageRoom));
  // Data is taken only once every access path has finished.
  assign sampleNow = (state == ST_COL) && (casLow >= accNeed) &&
    ((kind == K_READ) || (kind == K_RMW));
  // Early write data stands no later than CAS falls; late write data waits for OE off.
  assign driveWant = (isEarly && (state == ST_ROW || state == ST_COL_SET ||
    state == ST_COL)) || (state == ST_OE_OFF && tmr == 16'h0000 &&
    kind != K_READ) || (state == ST_WE_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Request latch.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      kind <= K_READ;
      row <= 10'h000;
      col <= 10'h000;
      wdata <= 4'h0;
    end
    else if (take)
    begin
      // A plain refresh during test mode is replaced so test mode survives.
      if (testActive && reqKind == K_CBR_REFRESH)
        kind <= K_TEST_ENTER;
      else
        kind <= reqKind;
      row <= reqRow;
      col <= reqCol;
      wdata <= reqData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_PAUSE;
      tmr <= 16'h0000;
      rasN <= 1'b1;
      casN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
      addr <= 10'h000;
      reqReady <= 1'b0;
      casFallP <= 1'b0;
    end
    else
    begin
      casFallP <= 1'b0;
      if (tmr != 16'h0000)
        tmr <= tmr - CNT_ONE;
      case (state)
        ST_PAUSE:
        begin
          if (tmr == 16'h0000 && !initDone && initCnt == 16'h0000 && rasLow == 16'h0000)
            tmr <= PAUSE_LOAD;
          else if (tmr == CNT_ONE)
          begin
            casN <= 1'b0;
            casFallP <= 1'b1;
            state <= ST_CBR_CAS;
          end
        end
        ST_IDLE:
        begin
          if (take)
          begin
            reqReady <= 1'b0;
            addr <= reqRow;
            if (reqKind == K_CBR_REFRESH || reqKind == K_TEST_ENTER ||
                reqKind == K_TEST_EXIT)
            begin
              casN <= 1'b0;
              casFallP <= 1'b1;
              weN <= !(reqKind == K_TEST_ENTER ||
                (testActive && reqKind == K_CBR_REFRESH));
              state <= ST_CBR_CAS;
            end
            else
              state <= ST_ROW_SET;
          end
          else
            reqReady <= 1'b1;
        end
        ST_ROW_SET:
        begin
          rasN <= 1'b0;
          weN <= !isEarly;
          state <= (kind == K_RAS_REFRESH) ? ST_END : ST_ROW;
        end
        ST_ROW:
        begin
          // CAS falls at the least delay so the RAS access figure holds.
          if (rasLow >= RCD_CYC)
          begin
            addr <= col;
            casN <= 1'b0;
            casFallP <= 1'b1;
            oeN <= !(kind == K_READ || kind == K_RMW);
            state <= ST_COL;
          end
        end
        ST_COL_SET:
        begin
          casN <= 1'b0;
          casFallP <= 1'b1;
          oeN <= !(kind == K_READ);
          state <= ST_COL;
        end
        ST_COL:
        begin
          if (kind == K_DELAYED_WRITE || (kind == K_RMW && sampleNow))
          begin
            oeN <= 1'b1;
            tmr <= OE_OFF_CYC - CNT_ONE;
            state <= ST_OE_OFF;
          end
          else if (sampleNow || (isEarly && casLow >= EW_CAS_CYC))
          begin
            casN <= 1'b1;
            oeN <= 1'b1;
            reqReady <= 1'b1;
            state <= ST_PAGE_GAP;
          end
        end
        ST_OE_OFF:
        begin
          if (tmr == 16'h0000 && (kind != K_RMW || casLow >= WE_DLY_CYC))
          begin
            weN <= 1'b0;
            tmr <= WE_LOW_CYC - CNT_ONE;
            state <= ST_WE_LOW;
          end
        end
        ST_WE_LOW:
        begin
          if (tmr == 16'h0000)
            state <= ST_END;
        end
        ST_PAGE_GAP:
        begin
          reqReady <= spacingOk && pageRoom;
          if (take)
          begin
            reqReady <= 1'b0;
            addr <= reqCol;
            state <= ST_COL_SET;
          end
          else if (!pageRoom || (reqValid && !pageMatch))
          begin
            reqReady <= 1'b0;
            state <= ST_END;
          end
        end
        ST_CBR_CAS:
        begin
          if (casLow >= COL_FIRST_SETUP_CYC)
          begin
            rasN <= 1'b0;
            state <= ST_END;
          end
        end
        ST_END:
        begin
          // CAS stays low as long as RAS in CAS-first refreshes, which covers the hold.
          if (rasLow >= RAS_CYC)
          begin
            rasN <= 1'b1;
            casN <= 1'b1;
            weN <= 1'b1;
            oeN <= 1'b1;
            tmr <= RP_CYC - CNT_ONE;
            state <= ST_PRECHARGE;
          end
        end
        ST_PRECHARGE:
        begin
          if (tmr == 16'h0000)
          begin
            if (!initDone && (initCnt + CNT_ONE) < INIT_REFRESHES)
            begin
              casN <= 1'b0;
              casFallP <= 1'b1;
              state <= ST_CBR_CAS;
            end
            else
            begin
              reqReady <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up refresh count.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      initCnt <= 16'h0000;
      initDone <= 1'b0;
    end
    else if (!initDone && state == ST_PRECHARGE && tmr == 16'h0000)
    begin
      initCnt <= initCnt + CNT_ONE;
      initDone <= (initCnt + CNT_ONE) >= INIT_REFRESHES;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test mode tracking and answers.

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      testActive <= 1'b0;
    else if (state == ST_CBR_CAS && casLow >= COL_FIRST_SETUP_CYC && initDone)
      testActive <= !weN;
    else if (state == ST_ROW_SET && kind == K_RAS_REFRESH)
      testActive <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rspValid <= 1'b0;
      testPass <= 1'b0;
    end
    else
    begin
      rspValid <= sampleNow;
      // The memory folds both tested bits into one level on the data pins.
      if (sampleNow && testActive)
        testPass <= dqIn[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on pin timing.

  a_cbr_setup_hold: assert property (@(posedge clk) disable iff (rst)
    ($fell(rasN) && !casN) |-> (!$past(casN) ##1 !casN))
    else $error("CAS not set up or held around RAS in a CAS-first refresh");

  a_oe_before_drive: assert property (@(posedge clk) disable iff (rst)
    $fell(dqOeN) |-> (oeN && $past(oeN) && $past(oeN, 2)))
    else $error("Data driven while memory outputs may be on");

  a_early_write: assert property (@(posedge clk) disable iff (rst)
    ($fell(casN) && !weN && !rasN) |-> (oeN && !dqOeN && !$past(weN)))
    else $error("Early write without data or WE set up before CAS");

  a_rmw_we_delay: assert property (@(posedge clk) disable iff (rst)
    ($fell(weN) && !rasN && kind == K_RMW) |-> ($past(casLow) >= WE_DLY_CYC))
    else $error("Read-modify-write WE fell too soon");

  a_sample_timing: assert property (@(posedge clk) disable iff (rst)
    rspValid |-> ($past(casLow) >= $past(accNeed) && $past(rasLow) >= ROW_ACCESS_CYC &&
    $past(weN)))
    else $error("Read data sampled before access time or during a write");

  a_page_limit: assert property (@(posedge clk) disable iff (rst)
    !rasN |-> (rasLow <= PAGE_LIMIT))
    else $error("RAS held low beyond the page maximum");

  a_page_spacing: assert property (@(posedge clk) disable iff (rst)
    $fell(casN) |-> ($past(casGap) >= PAGE_CYCLE_CYC - CNT_ONE))
    else $error("CAS cycles spaced closer than the page cycle time");

  a_init_count: assert property (@(posedge clk) disable iff (rst)
    $rose(initDone) |-> (initCnt == INIT_REFRESHES && rasN && casN))
    else $error("Initialization ended with the wrong refresh count");

  a_init_is_cbr: assert property (@(posedge clk) disable iff (rst)
    (!initDone && $fell(rasN)) |-> (!casN && weN))
    else $error("Initialization refresh was not CAS before RAS");

  a_test_enter: assert property (@(posedge clk) disable iff (rst)
    ($fell(rasN) && !casN && !weN && initDone) |-> testActive)
    else $error("Test mode not entered on WE and CAS first refresh");

  a_test_exit: assert property (@(posedge clk) disable iff (rst)
    ($fell(rasN) && ((!casN && weN) || (casN && kind == K_RAS_REFRESH))) |=> !testActive)
    else $error("Test mode not left on a plain refresh");

  a_test_refresh: assert property (@(posedge clk) disable iff (rst)
    (testActive && $fell(rasN) && !casN && kind != K_TEST_EXIT) |-> !weN)
    else $error("Refresh in test mode would leave test mode");

endmodule

// ==== logic/adc_data_pins.sv ====
// Purpose: Drives and samples the shared data pins of the memory.
// Assumes: dqIn is synchronous to clk.
// Notes: Drive and sample requests take effect at the next edge.
`timescale 1ns/1ps
module adc_data_pins
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests from the sequencer
  input wire logic driveWant,
  input wire logic [adc_pkg::DQ_W-1:0] wrData,
  input wire logic sampleNow,
  // Memory data pins
  input wire logic [adc_pkg::DQ_W-1:0] dqIn,
  output logic [adc_pkg::DQ_W-1:0] dqOut,
  output logic dqOeN,
  // Captured read data
  output logic [adc_pkg::DQ_W-1:0] rdData
);
  import adc_pkg::*;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dqOut <= 4'h0;
      dqOeN <= 1'b1;
    end
    else
    begin
      dqOut <= wrData;
      dqOeN <= !driveWant;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData <= 4'h0;
    else if (sampleNow)
      rdData <= dqIn;
  end
endmodule

// ==== logic/adc_delay_count.sv ====
// Purpose: Saturating count of cycles since a clear level was last seen.
// Assumes: clr is a flop output of the caller.
// Notes: Reads 1 in the first cycle after clr drops.
`timescale 1ns/1ps
module adc_delay_count
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  // Result
  output logic [adc_pkg::CNT_W-1:0] count
);
  import adc_pkg::*;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= 16'h0000;
    else if (clr)
      count <= CNT_ONE;
    else if (count != CNT_SAT)
      count <= count + CNT_ONE;
  end
endmodule

// ==== verif/adc_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the async DRAM cycle controller.
// Assumes: Short pause and page limits through parameters.
// Notes: A mismatching request in a page gap is held until IDLE takes it.
`timescale 1ns/1ps
module adc_ctrl_tb_top;
  import adc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  adc_kind_t reqKind = K_READ;
  logic [ADDR_W-1:0] reqRow = 10'h000;
  logic [ADDR_W-1:0] reqCol = 10'h000;
  logic [DQ_W-1:0] reqData = 4'h0;
  logic reqReady, rspValid, testPass, initDone, testActive;
  logic rasN, casN, weN, oeN, dqOeN;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] rspData, dqIn, dqOut;
  int errs;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic gapOpen = 1'b0;
  adc_kind_t gapKind = K_READ;
  logic [ADDR_W-1:0] gapRow = 10'h000;

  adc_ctrl #(.INIT_PAUSE_CYC(20), .PAGE_MAX_CYC(40)) i_dut
  (
    .clk(clk), .rst(rst), .reqValid(reqValid), .reqKind(reqKind), .reqRow(reqRow),
    .reqCol(reqCol), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .testPass(testPass), .initDone(initDone), .testActive(testActive),
    .rasN(rasN), .casN(casN), .weN(weN), .oeN(oeN), .addr(addr), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN)
  );
  adc_dram_model #(.PAUSE(20), .PMAX(40)) i_mem
  (
    .clk(clk), .rst(rst), .rasN(rasN), .casN(casN), .weN(weN), .oeN(oeN), .addr(addr),
    .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .errs(errs)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic hold(ref logic s, input logic v);
    int t;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (s !== v && t < 300);
    chk(s === v, "handshake lost");
  endtask

  // The row stays open after a read or early write, so a different request
  // is first refused there and taken only after the row closes.
  task automatic req(input adc_kind_t k, input logic [ADDR_W-1:0] r, c,
    input logic [DQ_W-1:0] d);
    int n;
    n = (gapOpen && (k != gapKind || r != gapRow)) ? 2 : 1;
    @(posedge clk);
    reqValid <= 1'b1;
    reqKind <= k;
    reqRow <= r;
    reqCol <= c;
    reqData <= d;
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
        hold(reqReady, 1'b0);
      hold(reqReady, 1'b1);
    end
    reqValid <= 1'b0;
    gapOpen = (k == K_READ || k == K_EARLY_WRITE);
    gapKind = k;
    gapRow = r;
  endtask

  task automatic rsp(input logic [DQ_W-1:0] e, input string m);
    hold(rspValid, 1'b1);
    chk(rspData === e, m);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] r, c, input logic [DQ_W-1:0] e);
    req(K_READ, r, c, 4'h0);
    rsp(e, "read data");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    hold(initDone, 1'b1);
    chk(testActive === 1'b0, "test mode after init");
  endtask

  task automatic t_wr();
    req(K_EARLY_WRITE, 10'h001, 10'h002, 4'hA);
    req(K_EARLY_WRITE, 10'h001, 10'h003, 4'h5);
    rdchk(10'h001, 10'h002, 4'hA);
    rdchk(10'h001, 10'h003, 4'h5);
  endtask

  task automatic t_late();
    req(K_DELAYED_WRITE, 10'h002, 10'h004, 4'hC);
    rdchk(10'h002, 10'h004, 4'hC);
    req(K_RMW, 10'h002, 10'h004, 4'h6);
    rsp(4'hC, "rmw old data");
    rdchk(10'h002, 10'h004, 4'h6);
  endtask

  task automatic t_test();
    req(K_EARLY_WRITE, 10'h003, 10'h000, 4'h3);
    req(K_EARLY_WRITE, 10'h003, 10'h001, 4'h1);
    req(K_TEST_ENTER, 10'h000, 10'h000, 4'h0);
    repeat (12) @(posedge clk);
    chk(testActive === 1'b1, "test entry");
    rdchk(10'h003, 10'h000, 4'hF);
    chk(testPass === 1'b1, "test match");
    rdchk(10'h003, 10'h001, 4'h0);
    chk(testPass === 1'b0, "test mismatch");
    req(K_CBR_REFRESH, 10'h000, 10'h000, 4'h0);
    repeat (12) @(posedge clk);
    chk(testActive === 1'b1, "test kept");
    rdchk(10'h003, 10'h000, 4'hF);
    req(K_TEST_EXIT, 10'h000, 10'h000, 4'h0);
    repeat (12) @(posedge clk);
    chk(testActive === 1'b0, "test exit");
    req(K_TEST_ENTER, 10'h000, 10'h000, 4'h0);
    req(K_RAS_REFRESH, 10'h005, 10'h000, 4'h0);
    repeat (12) @(posedge clk);
    chk(testActive === 1'b0, "row refresh exit");
    // A plain column-first refresh outside test mode keeps WE high.
    req(K_CBR_REFRESH, 10'h000, 10'h000, 4'h0);
    repeat (12) @(posedge clk);
    chk(testActive === 1'b0, "plain refresh stays normal");
    rdchk(10'h003, 10'h000, 4'h3);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_wr();
    t_late();
    t_test();
    // The last read leaves the row open until the page limit closes it.
    repeat (60) @(posedge clk);
    chk(errs == 0, "pin slips");
    final_report();
  end
endmodule

// ==== verif/adc_dram_model.sv ====
// Purpose: Behavioural 4-bit async DRAM that faces the controller.
// Assumes: Pins are sampled on clk; only row and column bits 3:0 are stored.
// Notes: Counts controller slips in errs; undriven data shows the inverse of the last word.
`timescale 1ns/1ps
module adc_dram_model
#(
  parameter int PAUSE = 20,
  parameter int PMAX = 40
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory pins
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic [adc_pkg::ADDR_W-1:0] addr,
  input wire logic [adc_pkg::DQ_W-1:0] dqOut,
  input wire logic dqOeN,
  output logic [adc_pkg::DQ_W-1:0] dqIn,
  // Slips seen
  output int errs
);
  import adc_pkg::*;
  logic [3:0] mem [256];
  logic [7:0] a;
  logic pr, pc, pw, early, test, casIn, live;
  logic [DQ_W-1:0] last, rd;
  int cyc, cnt, gap, rl, cl, cbr;
  wire rasF = pr && !rasN;
  wire casF = pc && !casN && !rasN;
  assign rd = test ? {4{mem[a][0] == mem[a][1]}} : mem[a];
  assign live = !rasN && !casN && !oeN && !early &&
    cnt >= (test ? int'(ACC_TEST_CYC) : int'(ACC_NORM_CYC)) - 1;
  // Data that is not yet valid must never look like a plausible old word.
  assign dqIn = live ? rd : ~last;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {pr, pc, pw} <= 3'h7;
      {early, test, casIn} <= 3'h0;
      last <= 4'h0;
      a <= 8'h00;
      {cyc, cnt, gap, rl, cl, cbr, errs} <= '0;
    end
    else
    begin
      pr <= rasN;
      pc <= casN;
      pw <= weN;
      cyc <= cyc + 1;
      cnt <= casF ? 1 : cnt + 1;
      gap <= casF ? 1 : gap + 1;
      rl <= rasN ? 0 : rl + 1;
      cl <= casN ? 0 : cl + 1;
      if (live)
        last <= rd;
      errs <= errs + int'(rl > PMAX)
        + int'(!oeN && !dqOeN)
        + int'(casF && casIn && gap < int'(PAGE_CYCLE_CYC))
        + int'(rasF && !casN && cl < int'(COL_FIRST_SETUP_CYC))
        + int'(rasF && cyc < PAUSE)
        + int'(casF && cbr < INIT_REFRESHES_N);
      if (rasF)
      begin
        a[7:4] <= addr[3:0];
        casIn <= 1'b0;
        if (!casN)
        begin
          cbr <= cbr + 1;
          test <= !weN;
        end
      end
      if (!pr && rasN && !casIn && pc)
        test <= 1'b0;
      if (casF)
      begin
        a[3:0] <= addr[3:0];
        casIn <= 1'b1;
        early <= !weN;
        if (!weN)
          mem[{a[7:4], addr[3:0]}] <= dqOut;
      end
      if (pw && !weN && !casN && !rasN && !early && !casF)
        mem[a] <= dqOut;
    end
  end
endmodule
